// ==== lsomc_params.svh ====
// Constants for the low-speed oscillator and operating-mode control block.
// Assumes inclusion by bare name from the package, the control module and the testbench.
`ifndef LSOMC_PARAMS_SVH
`define LSOMC_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define LSOMC_OFF_CTRL_ZERO   8'h00
`define LSOMC_OFF_CTRL_TWO    8'h04
`define LSOMC_OFF_STATUS      8'h08

// ****************************************************************
// Field positions
// ****************************************************************
`define LSOMC_BIT_LOW_POWER   0
`define LSOMC_BIT_CLK_SELECT  1
`define LSOMC_BIT_KEEP_RUN    0
`define LSOMC_BIT_MODE_LO     0
`define LSOMC_BIT_SLOW_OK     2
`define LSOMC_BIT_SLOW_RUN    3
`define LSOMC_BIT_SYSCLK_ON   4

// ****************************************************************
// Reset values
// ****************************************************************
`define LSOMC_RST_LOW_POWER   1'b0
`define LSOMC_RST_CLK_SELECT  1'b0
`define LSOMC_RST_KEEP_RUN    1'b1

// ****************************************************************
// Bus answers
// ****************************************************************
`define LSOMC_RESP_OKAY       2'h0
`define LSOMC_RESP_SLVERR     2'h2

`endif

// ==== lsomc_pkg.sv ====
// Types shared by the low-speed oscillator and mode control block.
// Assumes lsomc_params.svh sits in the same folder.
`include "lsomc_params.svh"

package lsomc_pkg;

    // ****************************************************************
    // Operating modes
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_SLOW   = 2'b01,
        MODE_IDLE   = 2'b10,
        MODE_SLEEP  = 2'b11
    } lsomc_mode_e;

    // High-speed source chosen by configuration option
    typedef enum logic [1:0] {
        FAST_EXT_XTAL = 2'b00,
        FAST_EXT_RC   = 2'b01,
        FAST_INT_RC   = 2'b10
    } lsomc_fast_e;

    // Static configuration options
    typedef struct packed {
        logic        large_variant;      // Dedicated slow crystal pins exist
        lsomc_fast_e fast_source;        // Selected high-speed oscillator
        logic        slow_xtal_enable;   // Low-speed crystal option chosen
        logic        slow_pins_as_gpio;  // Large variant: pins used as I/O
        logic        slow_rc_disable;    // Internal slow RC switched off
    } lsomc_cfg_s;

    // Oscillator and clock controls toward the analog cells
    typedef struct packed {
        logic       external_fast_crystal_osc_run;
        logic       external_rc_osc_run;
        logic       internal_fast_rc_osc_run;
        logic       low_speed_crystal_osc_run;
        logic       slow_xtal_low_power_sel;
        logic       internal_slow_rc_osc_run;
        logic       slow_xtal_pins_gpio;
        logic       sys_clk_enable;
        logic       sys_clk_slow;
    } lsomc_osc_s;

endpackage : lsomc_pkg

// ==== lsomc_ctrl.sv ====
// Operating-mode and low-speed oscillator control with an AXI4-Lite slave.
// Assumes configuration options are static and halt/wake come from the core
// on the same clock; the analog oscillators act on the osc output struct.
`timescale 1ns/1ps
`include "lsomc_params.svh"

module lsomc_ctrl
    import lsomc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Configuration options
    input  wire lsomc_cfg_s        cfg,
    // Core halt and wake events
    input  wire logic              halt_req,
    input  wire logic              wake_req,
    // Oscillator controls and mode
    output lsomc_osc_s             osc,
    output lsomc_mode_e            mode,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // ****************************************************************
    // Address decode
    // ****************************************************************

    typedef enum logic [1:0] {
        REG_ZERO   = 2'b00,
        REG_TWO    = 2'b01,
        REG_STATUS = 2'b10,
        REG_NONE   = 2'b11
    } lsomc_reg_e;

    // Shared by the read and write paths; low two address bits ignored
    function automatic lsomc_reg_e decode(input logic [ADDR_W-1:0] addr);
        logic [7:0] word;
        word = 8'(addr[ADDR_W-1:2]);
        if (word == 8'(`LSOMC_OFF_CTRL_ZERO >> 2)) begin
            decode = REG_ZERO;
        end else if (word == 8'(`LSOMC_OFF_CTRL_TWO >> 2)) begin
            decode = REG_TWO;
        end else if (word == 8'(`LSOMC_OFF_STATUS >> 2)) begin
            decode = REG_STATUS;
        end else begin
            decode = REG_NONE;
        end
    endfunction : decode

    // ****************************************************************
    // Control bits
    // ****************************************************************

    logic        slow_xtal_low_power_sel;
    logic        system_clock_select;
    logic        slow_xtal_keep_running;
    lsomc_mode_e next_mode;

    // Bus write capture
    logic [ADDR_W-1:0] aw_addr;
    logic              aw_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              w_held;
    logic              wr_fire;
    lsomc_reg_e        wr_reg;

    // One write lands per response; a pending answer blocks the next
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_reg  = decode(aw_addr);

    // ****************************************************************
    // Configuration-derived availability
    // ****************************************************************

    logic slow_xtal_configured;
    logic slow_xtal_on_halt;

    // Small parts share the fast oscillator pins with the crystal
    assign slow_xtal_configured = cfg.slow_xtal_enable &&
        (cfg.large_variant ? !cfg.slow_pins_as_gpio
                           : (cfg.fast_source == FAST_INT_RC));

    // Whether the crystal survives the halt instruction
    assign slow_xtal_on_halt = slow_xtal_configured &&
        (cfg.large_variant ? slow_xtal_keep_running
                           : 1'b1);

    // ****************************************************************
    // Control register writes
    // ****************************************************************

    // Low-power select: reset to quick start
    always_ff @(posedge clk) begin
        if (reset) begin
            slow_xtal_low_power_sel <= `LSOMC_RST_LOW_POWER;
        end else if (wr_fire && wr_reg == REG_ZERO && w_strb[0]) begin
            slow_xtal_low_power_sel <= w_data[`LSOMC_BIT_LOW_POWER];
        end
    end

    // Clock select register holds what software asked for
    always_ff @(posedge clk) begin
        if (reset) begin
            system_clock_select <= `LSOMC_RST_CLK_SELECT;
        end else if (wr_fire && wr_reg == REG_ZERO && w_strb[0]) begin
            system_clock_select <= w_data[`LSOMC_BIT_CLK_SELECT];
        end
    end

    // Keep-running bit exists on large parts only
    always_ff @(posedge clk) begin
        if (reset) begin
            slow_xtal_keep_running <= `LSOMC_RST_KEEP_RUN;
        end else if (wr_fire && wr_reg == REG_TWO && w_strb[0]
                     && cfg.large_variant) begin
            slow_xtal_keep_running <= w_data[`LSOMC_BIT_KEEP_RUN];
        end
    end

    // ****************************************************************
    // Mode state machine
    // ****************************************************************

    logic slow_wanted;

    // Without a crystal the select stays on the fast clock, no glitch
    assign slow_wanted = system_clock_select && slow_xtal_configured;

    // Halt ignores the clock select; wake returns to the selected run mode
    always_comb begin
        next_mode = mode;
        case (mode)
            MODE_NORMAL, MODE_SLOW: begin
                if (halt_req) begin
                    next_mode = slow_xtal_on_halt ? MODE_IDLE : MODE_SLEEP;
                end else begin
                    next_mode = slow_wanted ? MODE_SLOW : MODE_NORMAL;
                end
            end
            MODE_IDLE, MODE_SLEEP: begin
                if (wake_req) begin
                    next_mode = slow_wanted ? MODE_SLOW : MODE_NORMAL;
                end
            end
            default: begin
                next_mode = MODE_NORMAL;
            end
        endcase
    end

    // Mode register
    always_ff @(posedge clk) begin
        if (reset) begin
            mode <= MODE_NORMAL;
        end else begin
            mode <= next_mode;
        end
    end

    // ****************************************************************
    // Oscillator and clock controls
    // ****************************************************************

    logic running;
    logic fast_on;

    // Core clock runs only in Normal and Slow
    assign running = (mode == MODE_NORMAL) || (mode == MODE_SLOW);
    // Fast source only in Normal; Slow, Idle and Sleep stop it
    assign fast_on = (mode == MODE_NORMAL);

    // Registered so the analog controls never see decode glitches
    always_ff @(posedge clk) begin
        if (reset) begin
            osc <= '0;
        end else begin
            osc.external_fast_crystal_osc_run <=
                fast_on && cfg.fast_source == FAST_EXT_XTAL;
            osc.external_rc_osc_run <=
                fast_on && cfg.fast_source == FAST_EXT_RC;
            osc.internal_fast_rc_osc_run <=
                fast_on && cfg.fast_source == FAST_INT_RC;
            // Stopped only by Sleep; Slow and Idle keep it running
            osc.low_speed_crystal_osc_run <=
                slow_xtal_configured && (running || slow_xtal_on_halt);
            // Start-up time differs, oscillation itself does not
            osc.slow_xtal_low_power_sel <= slow_xtal_low_power_sel;
            osc.internal_slow_rc_osc_run <= !cfg.slow_rc_disable;
            osc.slow_xtal_pins_gpio <=
                cfg.large_variant && cfg.slow_pins_as_gpio;
            osc.sys_clk_enable <= running;
            osc.sys_clk_slow <= (mode == MODE_SLOW);
        end
    end

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************

    // Each half refused until the response handshake frees it
    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;

    // Address and data taken in either order, released after response
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_held <= 1'b0;
        end
    end

    // Write data holding
    always_ff @(posedge clk) begin
        if (reset) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_held <= 1'b0;
        end
    end

    // Response; status and unmapped words answer with an error
    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `LSOMC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_reg == REG_ZERO || wr_reg == REG_TWO)
                            ? `LSOMC_RESP_OKAY : `LSOMC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************

    logic [31:0] rd_word;
    lsomc_reg_e  rd_reg;

    // One read outstanding; the address waits while data stands
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_reg        = decode(s_axi_araddr);

    // Read mux; unused bits read as zero
    always_comb begin
        rd_word = '0;
        case (rd_reg)
            REG_ZERO: begin
                rd_word[`LSOMC_BIT_LOW_POWER]  = slow_xtal_low_power_sel;
                rd_word[`LSOMC_BIT_CLK_SELECT] = system_clock_select;
            end
            REG_TWO: begin
                // Absent on small parts, so it reads zero there
                rd_word[`LSOMC_BIT_KEEP_RUN] =
                    cfg.large_variant && slow_xtal_keep_running;
            end
            REG_STATUS: begin
                rd_word[`LSOMC_BIT_MODE_LO +: 2] = mode;
                rd_word[`LSOMC_BIT_SLOW_OK]  = slow_xtal_configured;
                rd_word[`LSOMC_BIT_SLOW_RUN] = osc.low_speed_crystal_osc_run;
                rd_word[`LSOMC_BIT_SYSCLK_ON] = osc.sys_clk_enable;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // Read data registered on the same edge that takes the address
    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= `LSOMC_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= (rd_reg == REG_NONE)
                            ? `LSOMC_RESP_SLVERR : `LSOMC_RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : lsomc_ctrl

// ==== lsomc_ctrl_sva.sv ====
// Checker for the mode and low-speed oscillator control block.
// Assumes static cfg and the osc struct lagging mode by one cycle.
`timescale 1ns/1ps
module lsomc_ctrl_sva
    import lsomc_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // Options and core events
    input wire lsomc_cfg_s  cfg,
    input wire logic        halt_req,
    input wire logic        wake_req,
    // Controls and mode
    input wire lsomc_osc_s  osc,
    input wire lsomc_mode_e mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // ****
    // Mode properties
    // ****
    // Halt from a running mode always lands in a halted mode
    property p_halt_go;
        halt_req && !wake_req && !mode[1] |=> mode[1];
    endproperty
    a_halt_go: assert property (p_halt_go) else $error("halt ignored");
    property p_idle_xtal;
        mode == MODE_IDLE && $stable(mode) |-> osc.low_speed_crystal_osc_run;
    endproperty
    a_idle_xtal: assert property (p_idle_xtal) else $error("idle without crystal");
    property p_sleep_xtal;
        mode == MODE_SLEEP && $stable(mode) |-> !osc.low_speed_crystal_osc_run;
    endproperty
    a_sleep_xtal: assert property (p_sleep_xtal) else $error("sleep with crystal");
    // Small parts with the crystal never reach Sleep
    property p_small_idle;
        halt_req && !mode[1] && !cfg.large_variant && cfg.slow_xtal_enable
            && cfg.fast_source == FAST_INT_RC |=> mode == MODE_IDLE;
    endproperty
    a_small_idle: assert property (p_small_idle) else $error("small part slept");
    property p_halt_clk;
        mode[1] && $stable(mode) |-> !osc.sys_clk_enable && !osc.internal_fast_rc_osc_run
            && !osc.external_fast_crystal_osc_run && !osc.external_rc_osc_run;
    endproperty
    a_halt_clk: assert property (p_halt_clk) else $error("clock on while halted");
    property p_slow_clk;
        mode == MODE_SLOW && $stable(mode) |-> osc.sys_clk_slow && osc.sys_clk_enable
            && !osc.internal_fast_rc_osc_run;
    endproperty
    a_slow_clk: assert property (p_slow_clk) else $error("slow clock wrong");
    property p_norm_clk;
        mode == MODE_NORMAL && $stable(mode) && !$past(reset) && !$past(reset, 2)
            |-> osc.sys_clk_enable && !osc.sys_clk_slow;
    endproperty
    a_norm_clk: assert property (p_norm_clk) else $error("normal clock wrong");
    // Slow mode only exists with a usable crystal
    property p_no_slow;
        !cfg.large_variant && cfg.fast_source != FAST_INT_RC
            |-> mode != MODE_SLOW && !osc.low_speed_crystal_osc_run;
    endproperty
    a_no_slow: assert property (p_no_slow) else $error("crystal on shared pins");
    property p_slow_rc;
        !$past(reset) && !$past(reset, 2)
            |-> osc.internal_slow_rc_osc_run == !cfg.slow_rc_disable;
    endproperty
    a_slow_rc: assert property (p_slow_rc) else $error("slow RC wrong");
    property p_pins;
        cfg.large_variant && cfg.slow_xtal_enable && !$past(reset) && !$past(reset, 2)
            |-> osc.slow_xtal_pins_gpio == cfg.slow_pins_as_gpio;
    endproperty
    a_pins: assert property (p_pins) else $error("pin option wrong");
endmodule : lsomc_ctrl_sva

bind lsomc_ctrl lsomc_ctrl_sva lsomc_ctrl_sva_inst (.clk(clk), .reset(reset), .cfg(cfg),
    .halt_req(halt_req), .wake_req(wake_req), .osc(osc), .mode(mode));

// ==== lsomc_core_model.sv ====
// Core-side partner: halt and wake pulses as the CPU issues them.
// Assumes the control block's clock; one pulse at a time.
`timescale 1ns/1ps
module lsomc_core_model (
    // Clock
    input  wire logic clk,
    // Core events
    output logic      halt_req,
    output logic      wake_req
);
    initial halt_req = 1'b0;
    initial wake_req = 1'b0;

    // One-cycle pulse, as the halt instruction gives
    task automatic halt;
        @(posedge clk);
        halt_req <= 1'b1;
        @(posedge clk);
        halt_req <= 1'b0;
    endtask : halt

    // Wake event; sequencing delays live outside this block
    task automatic wake;
        @(posedge clk);
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
    endtask : wake
endmodule : lsomc_core_model

// ==== low_speed_osc_mode_control_tb.sv ====
// Testbench: register accesses and halt/wake sequences per configuration.
// Assumes lsomc_ctrl, its checker and the core model compile first.
`timescale 1ns/1ps
`include "lsomc_params.svh"
module low_speed_osc_mode_control_tb;
    import lsomc_pkg::*;
    localparam logic [7:0] C0 = `LSOMC_OFF_CTRL_ZERO;
    localparam logic [7:0] C2 = `LSOMC_OFF_CTRL_TWO;
    localparam logic [7:0] SR = `LSOMC_OFF_STATUS;
    localparam logic [1:0] OK = `LSOMC_RESP_OKAY;
    localparam logic [1:0] ER = `LSOMC_RESP_SLVERR;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    lsomc_cfg_s  cfg = '0;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, halt_req, wake_req;
    logic [1:0]  bresp, rresp;
    lsomc_osc_s  osc;
    lsomc_mode_e mode;
    int          num_errors = 0, num_checks = 0;

    // 250 MHz clock
    always #2 clk = ~clk;

    lsomc_ctrl lsomc_ctrl_inst (.clk(clk), .reset(reset), .cfg(cfg), .halt_req(halt_req),
        .wake_req(wake_req), .osc(osc), .mode(mode), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    lsomc_core_model core_inst (.clk(clk), .halt_req(halt_req), .wake_req(wake_req));

    // ****
    // Helpers
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chkb
    // Options only change under reset, as they are static
    task automatic rst(input lsomc_cfg_s c);
        @(posedge clk);
        cfg <= c;
        reset <= 1'b1;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask : rst
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask : settle
    // Address and data offered together; bready held until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 64);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 64);
        rready <= 1'b0;
        chk(32'(rresp), 32'(er));
        chk(rdata, ed);
    endtask : rd
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    // ****
    // Tests
    // ****
    initial begin
        // Small part, internal RC with crystal
        rst(lsomc_cfg_s'({1'b0, FAST_INT_RC, 1'b1, 1'b0, 1'b0}));
        rd(SR, 32'h1C, OK);
        rd(C0, 32'h0, OK);
        wr(C0, 32'h1, OK);
        settle;
        chkb(osc.slow_xtal_low_power_sel, 1'b1);
        chkb(osc.low_speed_crystal_osc_run, 1'b1);
        wr(C0, 32'h3, OK);
        settle;
        chk(32'(mode), 32'(MODE_SLOW));
        chkb(osc.sys_clk_slow, 1'b1);
        rd(SR, 32'h1D, OK);
        core_inst.halt();
        settle;
        chk(32'(mode), 32'(MODE_IDLE));
        chkb(osc.sys_clk_enable, 1'b0);
        chkb(osc.internal_slow_rc_osc_run, 1'b1);
        core_inst.wake();
        settle;
        chk(32'(mode), 32'(MODE_SLOW));
        rd(8'h0C, 32'h0, ER);
        wr(SR, 32'h0, ER);
        $display("test 1 done");
        // Small part, external crystal excludes the slow crystal
        rst(lsomc_cfg_s'({1'b0, FAST_EXT_XTAL, 1'b1, 1'b0, 1'b1}));
        wr(C0, 32'h2, OK);
        settle;
        chk(32'(mode), 32'(MODE_NORMAL));
        chkb(osc.low_speed_crystal_osc_run, 1'b0);
        rd(SR, 32'h10, OK);
        core_inst.halt();
        settle;
        chk(32'(mode), 32'(MODE_SLEEP));
        chkb(osc.internal_slow_rc_osc_run, 1'b0);
        core_inst.wake();
        settle;
        $display("test 2 done");
        // Large part, external RC with crystal
        rst(lsomc_cfg_s'({1'b1, FAST_EXT_RC, 1'b1, 1'b0, 1'b0}));
        rd(C2, 32'h1, OK);
        chkb(osc.external_rc_osc_run, 1'b1);
        wr(C0, 32'h2, OK);
        settle;
        chk(32'(mode), 32'(MODE_SLOW));
        core_inst.halt();
        settle;
        chk(32'(mode), 32'(MODE_IDLE));
        core_inst.wake();
        settle;
        wr(C2, 32'h0, OK);
        core_inst.halt();
        settle;
        chk(32'(mode), 32'(MODE_SLEEP));
        chkb(osc.low_speed_crystal_osc_run, 1'b0);
        chkb(osc.sys_clk_enable, 1'b0);
        core_inst.wake();
        settle;
        $display("test 3 done");
        // Large part, crystal pins given to I/O
        rst(lsomc_cfg_s'({1'b1, FAST_INT_RC, 1'b1, 1'b1, 1'b0}));
        settle;
        chkb(osc.slow_xtal_pins_gpio, 1'b1);
        wr(C0, 32'h2, OK);
        settle;
        chk(32'(mode), 32'(MODE_NORMAL));
        $display("test 4 done");
        test_done();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("watchdog expired");
        test_done();
    end
endmodule : low_speed_osc_mode_control_tb
